// File: rtl/tpc_ctrl_regs.vh
/*
 * register offsets, field positions, reset values and timing counts for the
 * port role / converter control and line detect / termination control pair.
 * assumes: included once by each design file through the guard below.
 */
`ifndef TPC_CTRL_REGS_VH
`define TPC_CTRL_REGS_VH

// register offsets
`define TPC_OFS_ROLE        8'h09
`define TPC_OFS_LINE        8'h0A

// port role / converter control fields
`define TPC_ROLE_LSB        4
`define TPC_ROLE_MSB        6
`define TPC_AUTO_SRC_BIT    3
`define TPC_BOOST_ON_BIT    2
`define TPC_BUCK_ALLOW_BIT  1
`define TPC_CHG_ALLOW_BIT   0
`define TPC_ROLE_RST        8'h0B
`define TPC_ROLE_RW_MASK    8'h7F

// line detect / termination control fields
`define TPC_AUTO_LINE_BIT   5
`define TPC_FORCE_LINE_BIT  4
`define TPC_PULLUP_LSB      2
`define TPC_PULLUP_MSB      3
`define TPC_OVR_LSB         0
`define TPC_OVR_MSB         1
`define TPC_LINE_RST        8'h24
`define TPC_LINE_RW_MASK    8'h2F

// port role codes
`define TPC_ROLE_SINK       3'h0
`define TPC_ROLE_SOURCE     3'h1
`define TPC_ROLE_DRP        3'h2
`define TPC_ROLE_DRP_TSNK   3'h3
`define TPC_ROLE_DRP_TSRC   3'h4
`define TPC_ROLE_OFF        3'h5

// termination override codes
`define TPC_OVR_AUTO        2'h0
`define TPC_OVR_RD          2'h1
`define TPC_OVR_RP          2'h2
`define TPC_OVR_HIZ         2'h3

// pull-up current codes (80 uA, 180 uA, 330 uA)
`define TPC_RP_DEFAULT      2'h0
`define TPC_RP_1A5          2'h1
`define TPC_RP_3A0          2'h2

// line detection run length: 10 us at 20 MHz, sized to the run counter
`define TPC_DET_RUN_CYC     16'h00C8

`endif

// File: rtl/tpc_bit_sync.v
/*
 * two-flop synchroniser for a group of asynchronous level inputs.
 * assumes: inputs are slow levels; first stage feeds only the second.
 */
`timescale 1ns/1ps
module tpc_bit_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clock,
	input  wire             rst_n,
	// levels
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// first stage read only by the second
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

// File: rtl/tpc_ctrl_regs.v
/*
 * port role and converter control register pair (offsets 0x09 and 0x0a) with
 * the control outputs they steer: port role state reset, boost, buck, charge,
 * line detection start and termination selection.
 * assumes: a register access port from the serial interface on the same
 * clock (one-cycle write strobe, combinational read data); detection,
 * power-good, hold-off and source request levels arrive asynchronously
 * from the analog blocks and the port logic.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - the role field picks sink, source, dual-role, dual-role sink-first, source-first, or off.
// - writing a different port role returns the port state machine to unattached sink.
// - with automatic source control set boost follows detection, else the host governs it.
// - in automatic mode the device sets and clears the boost-on bit itself from detection.
// - a host write of 0 to boost-on turns boost off even in automatic mode.
// - in host mode the host reads its request status and writes boost-on 1 or 0 itself.
// - buck allow at 0 forces the buck converter off; at 1 it only permits it.
// - charge allow at 0 forces charging off; at 1 it only permits it.
// - automatic line detection starts a run once power is good and the hold-off has ended.
// - writing 1 to force line detection starts a run and the bit clears itself afterwards.
// - the pull-up current field advertises 80 uA, 180 uA or 330 uA in boost mode.
// - the override picks automatic, both Rd, both Rp at the selected current, or both open.
`include "tpc_ctrl_regs.vh"
module tpc_ctrl_regs (
	// clock and reset
	input  wire       clock,
	input  wire       rst_n,
	// register access
	input  wire [7:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	// device events
	input  wire       wdt_expire,
	input  wire       port_detect_source,
	input  wire       input_power_good,
	input  wire       holdoff_done,
	input  wire       host_source_request,
	// converter controls
	output reg        role_sm_reset,
	output reg  [2:0] port_role_select,
	output reg        boost_enable,
	output reg        buck_enable,
	output reg        charge_enable,
	output reg        line_detect_start,
	output reg        line_detect_busy,
	// termination controls
	output reg  [1:0] cc_term_mode,
	output reg  [1:0] pullup_current_sel,
	output wire       host_source_request_sts
);

	// termination modes driven to the analog front end
	localparam [1:0] TERM_RD  = 2'h0;
	localparam [1:0] TERM_RP  = 2'h1;
	localparam [1:0] TERM_HIZ = 2'h2;

	// detection run states, one-hot
	localparam [2:0] DET_IDLE = 3'h1;
	localparam [2:0] DET_RUN  = 3'h2;
	localparam [2:0] DET_DONE = 3'h4;

	localparam [15:0] DET_CYC = `TPC_DET_RUN_CYC;

	reg  [7:0]  role_q;
	reg  [7:0]  role_d;
	reg  [7:0]  line_q;
	reg  [7:0]  line_d;
	reg  [2:0]  det_q;
	reg  [2:0]  det_d;
	reg  [15:0] det_cnt_q;
	reg  [15:0] det_cnt_d;
	reg         auto_armed_q;
	reg         auto_armed_d;
	reg         src_seen_q;
	wire [3:0]  async_s;
	wire        det_src_s;
	wire        pgood_s;
	wire        holdoff_s;
	wire        wr_role;
	wire        wr_line;
	wire        auto_src;
	wire        src_rise;
	wire        src_fall;
	wire        det_trigger;

	// analog levels and the request status are resynchronised before use;
	// the first stage is never read here, only inside the synchroniser
	tpc_bit_sync #(
		.WIDTH(4)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({host_source_request, port_detect_source,
			input_power_good, holdoff_done}),
		.sync_out (async_s)
	);

	assign det_src_s = async_s[2];
	assign pgood_s   = async_s[1];
	assign holdoff_s = async_s[0];
	// request status reaches the host two cycles late, after the synchroniser
	assign host_source_request_sts = async_s[3];

	// address decode shared by write and read paths
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	// termination decode: override first, otherwise derived from the role
	function [1:0] term_sel;
		input [1:0] ovr;
		input [2:0] role;
		begin
			case (ovr)
				`TPC_OVR_RD:  term_sel = TERM_RD;
				`TPC_OVR_RP:  term_sel = TERM_RP;
				`TPC_OVR_HIZ: term_sel = TERM_HIZ;
				default:
					case (role)
						`TPC_ROLE_SOURCE: term_sel = TERM_RP;
						`TPC_ROLE_OFF:    term_sel = TERM_HIZ;
						default:          term_sel = TERM_RD;
					endcase
			endcase
		end
	endfunction

	assign wr_role  = reg_wr && hit(reg_addr, `TPC_OFS_ROLE);
	assign wr_line  = reg_wr && hit(reg_addr, `TPC_OFS_LINE);
	assign auto_src = role_q[`TPC_AUTO_SRC_BIT];
	assign src_rise = det_src_s && !src_seen_q;
	assign src_fall = !det_src_s && src_seen_q;

	// port role and converter control next value; the host clear is tested
	// before the automatic set so that a written 0 always wins
	always @*
	begin
		role_d = role_q;
		if (wdt_expire)
			role_d = `TPC_ROLE_RST;
		else
		begin
			if (wr_role)
				role_d = reg_wdata & `TPC_ROLE_RW_MASK;
			if (wr_role && !reg_wdata[`TPC_BOOST_ON_BIT])
				role_d[`TPC_BOOST_ON_BIT] = 1'b0;
			else if (auto_src && src_rise)
				role_d[`TPC_BOOST_ON_BIT] = 1'b1;
			else if (auto_src && src_fall)
				role_d[`TPC_BOOST_ON_BIT] = 1'b0;
		end
	end

	// auto line detection fires once per power-good session; a force write
	// that lands while a run is already going is absorbed by that run
	assign det_trigger = (line_q[`TPC_AUTO_LINE_BIT] && pgood_s && holdoff_s
		&& !auto_armed_q) || line_q[`TPC_FORCE_LINE_BIT];

	// line detect and termination next value
	always @*
	begin
		line_d = line_q;
		auto_armed_d = auto_armed_q;
		if (!pgood_s)
			auto_armed_d = 1'b0;
		else if (line_q[`TPC_AUTO_LINE_BIT] && holdoff_s && det_q == DET_IDLE)
			auto_armed_d = 1'b1;
		if (wdt_expire)
			line_d = (`TPC_LINE_RST & ~(8'h01 << `TPC_FORCE_LINE_BIT))
				| (line_q & (8'h01 << `TPC_FORCE_LINE_BIT));
		else if (wr_line)
			line_d = reg_wdata & `TPC_LINE_RW_MASK
				| (line_q & (8'h01 << `TPC_FORCE_LINE_BIT));
		if (wr_line && !wdt_expire && reg_wdata[`TPC_FORCE_LINE_BIT])
			line_d[`TPC_FORCE_LINE_BIT] = 1'b1;
		else if (det_q == DET_DONE)
			line_d[`TPC_FORCE_LINE_BIT] = 1'b0;
	end

	// detection run sequencer; the counter runs 0 .. DET_CYC-1 in DET_RUN,
	// so busy stands for exactly DET_CYC cycles
	always @*
	begin
		det_d = det_q;
		det_cnt_d = det_cnt_q;
		case (det_q)
			DET_IDLE:
			begin
				det_cnt_d = 16'h0000;
				if (det_trigger)
					det_d = DET_RUN;
			end
			DET_RUN:
			begin
				det_cnt_d = det_cnt_q + 16'h0001;
				if (det_cnt_q == DET_CYC - 16'h0001)
					det_d = DET_DONE;
			end
			DET_DONE:
				det_d = DET_IDLE;
			default:
				det_d = DET_IDLE;
		endcase
	end

	// state registers; the source edge detector resets low, the idle level
	// of its pin, so no false rise follows reset
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			role_q       <= `TPC_ROLE_RST;
			line_q       <= `TPC_LINE_RST;
			det_q        <= DET_IDLE;
			det_cnt_q    <= 16'h0000;
			auto_armed_q <= 1'b0;
			src_seen_q   <= 1'b0;
		end
		else
		begin
			role_q       <= role_d;
			line_q       <= line_d;
			det_q        <= det_d;
			det_cnt_q    <= det_cnt_d;
			auto_armed_q <= auto_armed_d;
			src_seen_q   <= det_src_s;
		end
	end

	// converter controls follow the register one cycle later; the role change
	// pulse compares next and current value, so a watchdog restore that moves
	// the role also resets the port state machine
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			role_sm_reset    <= 1'b0;
			port_role_select <= `TPC_ROLE_SINK;
			boost_enable     <= 1'b0;
			buck_enable      <= 1'b0;
			charge_enable    <= 1'b0;
		end
		else
		begin
			role_sm_reset <= role_d[`TPC_ROLE_MSB:`TPC_ROLE_LSB]
				!= role_q[`TPC_ROLE_MSB:`TPC_ROLE_LSB];
			port_role_select <= role_q[`TPC_ROLE_MSB:`TPC_ROLE_LSB];
			boost_enable  <= role_q[`TPC_BOOST_ON_BIT];
			buck_enable   <= role_q[`TPC_BUCK_ALLOW_BIT];
			charge_enable <= role_q[`TPC_CHG_ALLOW_BIT];
		end
	end

	// detection pulse and busy level; busy trails the sequencer by one cycle
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			line_detect_start <= 1'b0;
			line_detect_busy  <= 1'b0;
		end
		else
		begin
			line_detect_start <= (det_q == DET_IDLE) && det_trigger;
			line_detect_busy  <= (det_q == DET_RUN);
		end
	end

	// termination and advertised current towards the analog front end
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pullup_current_sel <= `TPC_RP_1A5;
			cc_term_mode       <= TERM_RD;
		end
		else
		begin
			pullup_current_sel <= line_q[`TPC_PULLUP_MSB:`TPC_PULLUP_LSB];
			cc_term_mode       <= term_sel(line_q[`TPC_OVR_MSB:`TPC_OVR_LSB],
				role_q[`TPC_ROLE_MSB:`TPC_ROLE_LSB]);
		end
	end

	// read mux; unmapped offsets read zero, reserved bits already zero
	// because the write masks never let them be set
	always @*
	begin
		if (hit(reg_addr, `TPC_OFS_ROLE))
			reg_rdata = role_q;
		else if (hit(reg_addr, `TPC_OFS_LINE))
			reg_rdata = line_q;
		else
			reg_rdata = 8'h00;
	end

endmodule

// File: tb/tpc_ctrl_regs_properties.sv
/* checker for the port role / line detect register pair.
   assumes: bound to tpc_ctrl_regs, one clock, async active-low reset. */
`timescale 1ns/1ps
`include "tpc_ctrl_regs.vh"
module tpc_ctrl_props (
	// clock and reset
	input	wire		clock,
	input	wire		rst_n,
	// register access
	input	wire	[7:0]	reg_addr,
	input	wire		reg_wr,
	input	wire	[7:0]	reg_wdata,
	input	wire	[7:0]	reg_rdata,
	input	wire		wdt_expire,
	input	wire		host_source_request,
	// controls
	input	wire		role_sm_reset,
	input	wire	[2:0]	port_role_select,
	input	wire		boost_enable,
	input	wire		buck_enable,
	input	wire		charge_enable,
	input	wire		line_detect_start,
	input	wire		line_detect_busy,
	input	wire	[1:0]	cc_term_mode,
	input	wire		host_source_request_sts
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// a write that the watchdog does not override
	wire		w9 = reg_wr && !wdt_expire && reg_addr == `TPC_OFS_ROLE;
	wire		wa = reg_wr && !wdt_expire && reg_addr == `TPC_OFS_LINE;
	wire	[2:0]	wrole = reg_wdata[6:4];
	reg	[8:0]	busy_q;
	// length of the current busy stretch, for the run-length check
	always @(posedge clock or negedge rst_n)
		if (!rst_n)
			busy_q <= 9'h000;
		else
			busy_q <= line_detect_busy ? busy_q + 9'h001 : 9'h000;
	a_role_change: assert property (
		w9 && wrole != reg_rdata[6:4] |=> role_sm_reset ##1 port_role_select == $past(wrole, 2))
		else $error("role change not applied");
	a_resv_zero: assert property (
		!reg_rdata[7] && (reg_addr != `TPC_OFS_LINE || !reg_rdata[6]))
		else $error("reserved bit reads one");
	a_buck_off: assert property (w9 && !reg_wdata[1] |=> ##1 !buck_enable)
		else $error("buck not forced off");
	a_chg_off: assert property (w9 && !reg_wdata[0] |=> ##1 !charge_enable)
		else $error("charge not forced off");
	a_boost_clear: assert property (w9 && !reg_wdata[2] |=> ##1 !boost_enable)
		else $error("boost not cleared");
	a_force_start: assert property (
		wa && reg_wdata[4] && !line_detect_busy |-> ##[1:2] line_detect_start)
		else $error("forced detection did not start");
	a_run_length: assert property ($fell(line_detect_busy) |-> busy_q == `TPC_DET_RUN_CYC)
		else $error("detection run length wrong");
	a_start_busy: assert property (line_detect_start |-> ##[0:1] line_detect_busy)
		else $error("start without busy");
	a_term_hiz: assert property (
		!reg_wr && !wdt_expire && reg_addr == `TPC_OFS_LINE && reg_rdata[1:0] == `TPC_OVR_HIZ
		|=> cc_term_mode == 2'h2)
		else $error("termination not open");
	a_wdt_restore: assert property (
		wdt_expire ##1 !reg_wr |=> buck_enable && charge_enable && !boost_enable)
		else $error("watchdog defaults missing");
	a_sts_pass: assert property (host_source_request_sts == $past(host_source_request, 2))
		else $error("request status not passed");
endmodule
bind tpc_ctrl_regs tpc_ctrl_props i_tpc_ctrl_props (
	.clock                   (clock),
	.rst_n                   (rst_n),
	.reg_addr                (reg_addr),
	.reg_wr                  (reg_wr),
	.reg_wdata               (reg_wdata),
	.reg_rdata               (reg_rdata),
	.wdt_expire              (wdt_expire),
	.host_source_request     (host_source_request),
	.role_sm_reset           (role_sm_reset),
	.port_role_select        (port_role_select),
	.boost_enable            (boost_enable),
	.buck_enable             (buck_enable),
	.charge_enable           (charge_enable),
	.line_detect_start       (line_detect_start),
	.line_detect_busy        (line_detect_busy),
	.cc_term_mode            (cc_term_mode),
	.host_source_request_sts (host_source_request_sts)
);

// File: tb/tpc_far_side.sv
/* far side model: port partner detection, power good, hold-off, request.
   assumes: level commands from the bench; output levels are asynchronous. */
`timescale 1ns/1ps
module tpc_far_side (
	// commands
	input	wire	clock,
	input	wire	src_cmd,
	input	wire	pgood_cmd,
	input	wire	hold_cmd,
	input	wire	req_cmd,
	// levels to the device
	output	reg	port_detect_source,
	output	reg	input_power_good,
	output	reg	holdoff_done,
	output	reg	host_source_request
);
	initial {port_detect_source, input_power_good, holdoff_done, host_source_request} = 4'h0;
	// odd offset so the levels never move with the device clock edge
	always @(posedge clock)
		#17 {port_detect_source, input_power_good, holdoff_done} <= {src_cmd, pgood_cmd, hold_cmd};
	always @(posedge clock)
		#17 host_source_request <= req_cmd;
endmodule

// File: tb/testbench.sv
/* bench: random and corner writes through the register port.
   assumes: design, far side model and checker compiled before it. */
`timescale 1ns/1ps
module testbench;
	reg		clock = 0, rst_n = 0, reg_wr = 0, wdt_expire = 0, f;
	reg	[7:0]	reg_addr = 0, reg_wdata = 0, d9, da;
	reg		src_cmd = 0, pgood_cmd = 0, hold_cmd = 0, req_cmd = 0;
	wire		port_detect_source, input_power_good, holdoff_done, host_source_request;
	wire		role_sm_reset, boost_enable, buck_enable, charge_enable;
	wire		line_detect_start, line_detect_busy, host_source_request_sts;
	wire	[7:0]	reg_rdata;
	wire	[2:0]	port_role_select;
	wire	[1:0]	cc_term_mode, pullup_current_sel;
	integer		seed = 1, mismatches = 0, num_checks = 0, i, k;
	tpc_far_side i_tpc_far_side (
		.clock               (clock),
		.src_cmd             (src_cmd),
		.pgood_cmd           (pgood_cmd),
		.hold_cmd            (hold_cmd),
		.req_cmd             (req_cmd),
		.port_detect_source  (port_detect_source),
		.input_power_good    (input_power_good),
		.holdoff_done        (holdoff_done),
		.host_source_request (host_source_request)
	);
	tpc_ctrl_regs i_tpc_ctrl_regs (
		.clock                   (clock),
		.rst_n                   (rst_n),
		.reg_addr                (reg_addr),
		.reg_wr                  (reg_wr),
		.reg_wdata               (reg_wdata),
		.reg_rdata               (reg_rdata),
		.wdt_expire              (wdt_expire),
		.port_detect_source      (port_detect_source),
		.input_power_good        (input_power_good),
		.holdoff_done            (holdoff_done),
		.host_source_request     (host_source_request),
		.role_sm_reset           (role_sm_reset),
		.port_role_select        (port_role_select),
		.boost_enable            (boost_enable),
		.buck_enable             (buck_enable),
		.charge_enable           (charge_enable),
		.line_detect_start       (line_detect_start),
		.line_detect_busy        (line_detect_busy),
		.cc_term_mode            (cc_term_mode),
		.pullup_current_sel      (pullup_current_sel),
		.host_source_request_sts (host_source_request_sts)
	);
	initial forever #25 clock = ~clock;
	task chk(input [7:0] s, input [7:0] e);
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			mismatches = mismatches + 1;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clock) #2;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge clock) #2;
		reg_wr = 0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(posedge clock) #2;
		reg_addr = a;
		#1 chk(reg_rdata, e);
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	// f records whether a detection start pulse showed within n cycles
	task ws(input integer n);
		f = 0;
		repeat (n)
		begin
			@(posedge clock);
			#1 if (line_detect_start === 1'b1) f = 1;
		end
	endtask
	task wb;
		k = 0;
		while (line_detect_busy !== 1'b0 && k < 400)
		begin
			@(posedge clock) #1;
			k = k + 1;
		end
		if (k >= 400)
		begin
			mismatches = mismatches + 1;
			tally_and_finish;
		end
	endtask
	// termination expected from role and override fields
	function [1:0] term(input [2:0] r, input [1:0] o);
		term = o == 1 ? 0 : o == 2 ? 1 : o == 3 ? 2 : r == 1 ? 1 : r == 5 ? 2 : 0;
	endfunction
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge clock);
		#2 rst_n = 1;
		rd(8'h09, 8'h0B);
		rd(8'h0A, 8'h24);
		rd(8'h0B, 8'h00);
		chk(pullup_current_sel, 2'h1);
		for (i = 0; i < 6; i = i + 1)
		begin
			wr(8'h09, {1'b1, i[2:0], 4'h3});
			rd(8'h09, {1'b0, i[2:0], 4'h3});
			cyc(1);
			chk(port_role_select, i[2:0]);
		end
		// random fields; force bit kept low so no run starts here
		for (i = 0; i < 12; i = i + 1)
		begin
			d9 = $random(seed);
			da = $random(seed);
			d9[6:4] = d9[6:4] % 3'h6;
			da[4] = 0;
			wr(8'h09, d9);
			wr(8'h0A, da);
			cyc(2);
			chk({boost_enable, buck_enable, charge_enable}, d9[2:0]);
			chk(pullup_current_sel, da[3:2]);
			chk(cc_term_mode, term(d9[6:4], da[1:0]));
			rd(8'h09, d9 & 8'h7F);
			rd(8'h0A, da & 8'h2F);
		end
		wr(8'h09, 8'h0B);
		src_cmd = 1;
		cyc(6);
		rd(8'h09, 8'h0F);
		chk(boost_enable, 1'b1);
		wr(8'h09, 8'h0B);
		cyc(2);
		chk(boost_enable, 1'b0);
		src_cmd = 0;
		cyc(6);
		src_cmd = 1;
		cyc(6);
		rd(8'h09, 8'h0F);
		src_cmd = 0;
		cyc(6);
		rd(8'h09, 8'h0B);
		wr(8'h09, 8'h03);
		src_cmd = 1;
		req_cmd = 1;
		cyc(6);
		rd(8'h09, 8'h03);
		chk(host_source_request_sts, 1'b1);
		wr(8'h09, 8'h07);
		cyc(2);
		chk(boost_enable, 1'b1);
		src_cmd = 0;
		req_cmd = 0;
		wr(8'h0A, 8'h04);
		pgood_cmd = 1;
		hold_cmd = 1;
		ws(12);
		chk(f, 1'b0);
		wr(8'h0A, 8'h24);
		ws(12);
		chk(f, 1'b1);
		wb;
		wr(8'h0A, 8'h34);
		ws(4);
		chk(f, 1'b1);
		wb;
		rd(8'h0A, 8'h24);
		wr(8'h09, 8'h00);
		wr(8'h0A, 8'h00);
		// watchdog and a write in the same cycle: watchdog wins
		@(posedge clock) #2;
		reg_addr = 8'h09;
		reg_wdata = 8'h70;
		reg_wr = 1;
		wdt_expire = 1;
		@(posedge clock) #2;
		reg_wr = 0;
		wdt_expire = 0;
		cyc(2);
		rd(8'h09, 8'h0B);
		rd(8'h0A, 8'h24);
		chk({boost_enable, buck_enable, charge_enable}, 3'h3);
		tally_and_finish;
	end
endmodule
